// ### eipf_pkg.sv
package eipf_pkg;

   // ==========================================================
   // Register map (byte addresses)
   localparam int              AXI_AW      = 8;
   localparam logic [AXI_AW-1:0] ADDR_TIMER_CONTROL_REG = 8'h88;
   localparam logic [AXI_AW-1:0] ADDR_SKIP = 8'hd4;
   localparam logic [AXI_AW-1:0] ADDR_CFG  = 8'he4;
   localparam logic [AXI_AW-1:0] ADDR_STAT = 8'hf0;
   localparam logic [AXI_AW-1:0] ADDR_MASK = 8'hf4;

   // ==========================================================
   // Reset values
   localparam logic [7:0]  CFG_RST  = 8'h01;
   localparam logic [1:0]  EDGE_RST = 2'h0;
   localparam logic [15:0] SKIP_RST = 16'h0000;
   localparam logic [1:0]  STAT_RST = 2'h0;
   localparam logic [1:0]  MASK_RST = 2'h0;

   // ==========================================================
   // Field positions
   localparam int CFG_A_SEL = 0;
   localparam int CFG_A_POL = 3;
   localparam int CFG_B_SEL = 4;
   localparam int CFG_B_POL = 7;
   localparam int TC_A_EDGE = 0;
   localparam int TC_A_PEND = 1;
   localparam int TC_B_EDGE = 2;
   localparam int TC_B_PEND = 3;

   // ==========================================================
   // Pin select codes
   localparam logic [2:0] SEL_P0_MAX = 3'h4;
   localparam logic [2:0] SEL_P16    = 3'h5;
   localparam logic [2:0] SEL_P17    = 3'h7;

   // ==========================================================
   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic filt;
      logic act_prev;
      logic pend;
      logic evt;
   } eipf_chan_st_t;

   typedef struct packed {
      logic              aw_got;
      logic              w_got;
      logic [AXI_AW-1:0] awaddr;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic [7:0]        cfg;
      logic [1:0]        edge_mode;
      logic [15:0]       skip;
      logic [1:0]        status;
      logic [1:0]        mask;
      logic              irq;
   } eipf_top_st_t;

   // Byte-lane merge of a write into a register image
   function automatic logic [31:0] eipf_wr_merge(input logic [31:0] old,
                                                 input logic [31:0] data,
                                                 input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      return res;
   endfunction

endpackage

// ### eipf_pinmux.sv
`timescale 1ns/1ps
module eipf_pinmux
   import eipf_pkg::*;
(
   input  wire logic [7:0] p0_pins,
   input  wire logic [7:0] p1_pins,
   input  wire logic [2:0] sel,
   input  wire logic       aclk,
   input  wire logic       aresetn,
   output logic            pin_out
);

   // ==========================================================
   // Pin routing, read only
   always_comb begin
      pin_out = 1'b0;
      if (sel <= SEL_P0_MAX) begin
         pin_out = p0_pins[sel];                  // [RULE_03] [RULE_04]
      end else if (sel == SEL_P16) begin
         pin_out = p1_pins[6];
      end else if (sel == SEL_P17) begin
         pin_out = p1_pins[7];                    // [RULE_03]
      end
   end

   // ==========================================================
   // Checks
   property p_mux_p0;
      @(posedge aclk) disable iff (!aresetn)
      (sel <= SEL_P0_MAX) |-> (pin_out == p0_pins[sel]);
   endproperty
   a_mux_p0 : assert property (p_mux_p0) // [RULE_03]
      else $error("Port 0 pin not routed");

   property p_mux_p17;
      @(posedge aclk) disable iff (!aresetn)
      (sel == SEL_P17) |-> (pin_out == p1_pins[7]);
   endproperty
   a_mux_p17 : assert property (p_mux_p17) // [RULE_03]
      else $error("Port 1 pin 7 not routed");

endmodule

// ### eipf_chan.sv
`timescale 1ns/1ps
module eipf_chan
   import eipf_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic pin_raw,
   input  wire logic edge_mode,
   input  wire logic polarity,
   input  wire logic vec_ack,
   input  wire logic sw_wr,
   input  wire logic sw_val,
   output logic      pending,
   output logic      event_p
);

   eipf_chan_st_t st_r;
   eipf_chan_st_t st_nxt;
   logic          active;
   logic          hit;

   // ==========================================================
   // Sync, polarity, edge detect, pending
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = pin_raw;                        // [RULE_11]
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      if (st_r.s2 == st_r.s3) begin
         st_nxt.filt = st_r.s3;                   // [RULE_11]
      end
      active          = polarity ? st_r.filt : ~st_r.filt; // [RULE_02]
      hit             = active & ~st_r.act_prev;
      st_nxt.act_prev = active;
      st_nxt.evt      = hit;
      if (edge_mode) begin                        // [RULE_01]
         if (hit) begin
            st_nxt.pend = 1'b1;                   // [RULE_07]
         end else if (vec_ack) begin
            st_nxt.pend = 1'b0;                   // [RULE_07]
         end else if (sw_wr) begin
            st_nxt.pend = sw_val;
         end
      end else begin
         st_nxt.pend = active;                    // [RULE_08] [RULE_09] [RULE_10]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r          <= '0;
         st_r.act_prev <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pending = st_r.pend;
   assign event_p = st_r.evt;

   // ==========================================================
   // Checks
   property p_level_follow;
      @(posedge aclk) disable iff (!aresetn)
      ($past(aresetn) && !edge_mode && $past(!edge_mode) && $stable(polarity))
         |-> (pending == (polarity ? $past(st_r.filt) : !$past(st_r.filt)));
   endproperty
   a_level_follow : assert property (p_level_follow) // [RULE_08]
      else $error("Level pending does not follow input");

   property p_pol_edge;
      @(posedge aclk) disable iff (!aresetn)
      (edge_mode && $stable(polarity)
         && (polarity ? $rose(st_r.filt) : $fell(st_r.filt))) |=> pending;
   endproperty
   a_pol_edge : assert property (p_pol_edge) // [RULE_02]
      else $error("Active edge did not set pending");

   property p_vec_clear;
      @(posedge aclk) disable iff (!aresetn)
      (edge_mode && vec_ack && !hit) |=> !pending;
   endproperty
   a_vec_clear : assert property (p_vec_clear) // [RULE_07]
      else $error("Vector did not clear pending");

   property p_edge_hold;
      @(posedge aclk) disable iff (!aresetn)
      (edge_mode && !hit && !vec_ack && !sw_wr) |=> $stable(pending);
   endproperty
   a_edge_hold : assert property (p_edge_hold) // [RULE_01]
      else $error("Edge pending changed without cause");

   property p_sync;
      @(posedge aclk) disable iff (!aresetn)
      $changed(st_r.filt) |-> ((st_r.filt == $past(st_r.s3))
                               && ($past(st_r.s2) == $past(st_r.s3)));
   endproperty
   a_sync : assert property (p_sync) // [RULE_11]
      else $error("Filtered input changed before settling");

endmodule

// ### eipf_top.sv
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
// How it works
// RULE_01: Edge-mode bit 1 makes an input edge sensitive, 0 level sensitive.
// RULE_02: Polarity bit 0 means active low, 1 active high, in both modes.
// RULE_03: Three-bit pin selects at 6:4 and 2:0 route port pins to inputs.
// RULE_04: Inputs only watch their pin and never disturb the pin's peripheral.
// RULE_05: Skipped pins are kept from peripherals, serving only the interrupt.
// RULE_06: Pending flags sit at bits 1 and 3 of the timer control register.
// RULE_07: Edge mode sets pending on active edge, cleared when CPU vectors.
// RULE_08: Level mode pending simply follows the active level, never latched.
// RULE_09: Source holds a level request active until it is recognised.
// RULE_10: Source drops a level request before the handler ends, else re-request.
// RULE_11: Selected pin is synchronised before polarity and edge detection.
module eipf_top
   import eipf_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [AXI_AW-1:0] awaddr,
   input  wire logic              wvalid,
   output logic                   wready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   output logic                   bvalid,
   input  wire logic              bready,
   output logic [1:0]             bresp,
   input  wire logic              arvalid,
   output logic                   arready,
   input  wire logic [AXI_AW-1:0] araddr,
   output logic                   rvalid,
   input  wire logic              rready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   input  wire logic [7:0]        p0_pins,
   input  wire logic [7:0]        p1_pins,
   input  wire logic              vec_ack_a,
   input  wire logic              vec_ack_b,
   output logic                   irq_a_pending,
   output logic                   irq_b_pending,
   output logic [7:0]             xbar_skip_p0,
   output logic [7:0]             xbar_skip_p1,
   output logic                   irq
);

   eipf_top_st_t      st_r;
   eipf_top_st_t      st_nxt;
   logic              pin_a;
   logic              pin_b;
   logic              evt_a;
   logic              evt_b;
   logic              aw_hs;
   logic              w_hs;
   logic              ar_hs;
   logic              do_wr;
   logic              rd_clr;
   logic [AXI_AW-1:0] wr_addr;
   logic [31:0]       wr_data;
   logic [3:0]        wr_strb;
   logic [31:0]       merged;
   logic [31:0]       timer_control_reg_img;
   logic              pw_a;
   logic              pw_b;
   logic              pw_val_a;
   logic              pw_val_b;

   // ==========================================================
   // Pin routing
   eipf_pinmux u_mux_a (
      .p0_pins (p0_pins),
      .p1_pins (p1_pins),
      .sel     (st_r.cfg[CFG_A_SEL +: 3]),
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_out (pin_a)
   );

   eipf_pinmux u_mux_b (
      .p0_pins (p0_pins),
      .p1_pins (p1_pins),
      .sel     (st_r.cfg[CFG_B_SEL +: 3]),
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_out (pin_b)
   );

   // ==========================================================
   // Interrupt channels
   eipf_chan u_chan_a (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .pin_raw   (pin_a),
      .edge_mode (st_r.edge_mode[0]),
      .polarity  (st_r.cfg[CFG_A_POL]),
      .vec_ack   (vec_ack_a),
      .sw_wr     (pw_a),
      .sw_val    (pw_val_a),
      .pending   (irq_a_pending),
      .event_p   (evt_a)
   );

   eipf_chan u_chan_b (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .pin_raw   (pin_b),
      .edge_mode (st_r.edge_mode[1]),
      .polarity  (st_r.cfg[CFG_B_POL]),
      .vec_ack   (vec_ack_b),
      .sw_wr     (pw_b),
      .sw_val    (pw_val_b),
      .pending   (irq_b_pending),
      .event_p   (evt_b)
   );

   // ==========================================================
   // Bus handshakes
   assign awready = !st_r.aw_got && !st_r.bvalid;
   assign wready  = !st_r.w_got && !st_r.bvalid;
   assign arready = !st_r.rvalid;
   assign aw_hs   = awvalid && awready;
   assign w_hs    = wvalid && wready;
   assign ar_hs   = arvalid && arready;
   assign wr_addr = st_r.aw_got ? st_r.awaddr : awaddr;
   assign wr_data = st_r.w_got ? st_r.wdata : wdata;
   assign wr_strb = st_r.w_got ? st_r.wstrb : wstrb;
   assign do_wr   = (st_r.aw_got || aw_hs) && (st_r.w_got || w_hs) && !st_r.bvalid;
   assign rd_clr  = ar_hs && (araddr == ADDR_STAT);

   // Timer control image, only the interrupt bits are held here
   always_comb begin
      timer_control_reg_img            = 32'h0000_0000;
      timer_control_reg_img[TC_A_EDGE] = st_r.edge_mode[0];
      timer_control_reg_img[TC_A_PEND] = irq_a_pending;        // [RULE_06]
      timer_control_reg_img[TC_B_EDGE] = st_r.edge_mode[1];
      timer_control_reg_img[TC_B_PEND] = irq_b_pending;        // [RULE_06]
   end

   // ==========================================================
   // Next state
   always_comb begin
      st_nxt   = st_r;
      merged   = 32'h0000_0000;
      pw_a     = 1'b0;
      pw_b     = 1'b0;
      pw_val_a = 1'b0;
      pw_val_b = 1'b0;
      if (aw_hs) begin
         st_nxt.aw_got = 1'b1;
         st_nxt.awaddr = awaddr;
      end
      if (w_hs) begin
         st_nxt.w_got = 1'b1;
         st_nxt.wdata = wdata;
         st_nxt.wstrb = wstrb;
      end
      if (st_r.bvalid && bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (do_wr) begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got  = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp  = RESP_OKAY;
         case (wr_addr)
            ADDR_TIMER_CONTROL_REG: begin
               merged           = eipf_wr_merge(timer_control_reg_img, wr_data, wr_strb);
               st_nxt.edge_mode = {merged[TC_B_EDGE], merged[TC_A_EDGE]}; // [RULE_01]
               pw_a             = wr_strb[0];
               pw_b             = wr_strb[0];
               pw_val_a         = merged[TC_A_PEND];
               pw_val_b         = merged[TC_B_PEND];
            end
            ADDR_CFG: begin
               merged     = eipf_wr_merge({24'h0, st_r.cfg}, wr_data, wr_strb);
               st_nxt.cfg = merged[7:0];          // [RULE_02] [RULE_03]
            end
            ADDR_SKIP: begin
               merged      = eipf_wr_merge({16'h0, st_r.skip}, wr_data, wr_strb);
               st_nxt.skip = merged[15:0];        // [RULE_05]
            end
            ADDR_MASK: begin
               merged      = eipf_wr_merge({30'h0, st_r.mask}, wr_data, wr_strb);
               st_nxt.mask = merged[1:0];
            end
            ADDR_STAT: begin
               st_nxt.bresp = RESP_OKAY;
            end
            default: begin
               st_nxt.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (st_r.rvalid && rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (ar_hs) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp  = RESP_OKAY;
         case (araddr)
            ADDR_TIMER_CONTROL_REG: st_nxt.rdata = timer_control_reg_img;   // [RULE_06]
            ADDR_CFG:  st_nxt.rdata = {24'h0, st_r.cfg};
            ADDR_SKIP: st_nxt.rdata = {16'h0, st_r.skip};
            ADDR_STAT: st_nxt.rdata = {30'h0, st_r.status};
            ADDR_MASK: st_nxt.rdata = {30'h0, st_r.mask};
            default: begin
               st_nxt.rdata = 32'h0000_0000;
               st_nxt.rresp = RESP_SLVERR;
            end
         endcase
      end
      // Sticky events, a new event beats the read clear
      st_nxt.status = (rd_clr ? 2'h0 : st_r.status) | {evt_b, evt_a};
      st_nxt.irq    = |(st_nxt.status & st_nxt.mask);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r           <= '0;
         st_r.cfg       <= CFG_RST;
         st_r.edge_mode <= EDGE_RST;
         st_r.skip      <= SKIP_RST;
         st_r.status    <= STAT_RST;
         st_r.mask      <= MASK_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign bvalid       = st_r.bvalid;
   assign bresp        = st_r.bresp;
   assign rvalid       = st_r.rvalid;
   assign rdata        = st_r.rdata;
   assign rresp        = st_r.rresp;
   assign xbar_skip_p0 = st_r.skip[7:0];          // [RULE_05]
   assign xbar_skip_p1 = st_r.skip[15:8];
   assign irq          = st_r.irq;

   // ==========================================================
   // Checks
   property p_timer_control_reg_read;
      @(posedge aclk) disable iff (!aresetn)
      (ar_hs && (araddr == ADDR_TIMER_CONTROL_REG))
         |=> (rdata[TC_A_PEND] == $past(irq_a_pending))
             && (rdata[TC_B_PEND] == $past(irq_b_pending));
   endproperty
   a_timer_control_reg_read : assert property (p_timer_control_reg_read) // [RULE_06]
      else $error("Pending flags misplaced in timer control");

   property p_skip_wr;
      @(posedge aclk) disable iff (!aresetn)
      (do_wr && (wr_addr == ADDR_SKIP) && wr_strb[0])
         |=> (xbar_skip_p0 == $past(wr_data[7:0]));
   endproperty
   a_skip_wr : assert property (p_skip_wr) // [RULE_05]
      else $error("Skip mask not updated");

   property p_edge_wr;
      @(posedge aclk) disable iff (!aresetn)
      (do_wr && (wr_addr == ADDR_TIMER_CONTROL_REG) && wr_strb[0])
         |=> (st_r.edge_mode == {$past(wr_data[TC_B_EDGE]), $past(wr_data[TC_A_EDGE])});
   endproperty
   a_edge_wr : assert property (p_edge_wr) // [RULE_01]
      else $error("Edge mode bits not updated");

   property p_set_wins;
      @(posedge aclk) disable iff (!aresetn)
      (rd_clr && evt_a) |=> st_r.status[0];
   endproperty
   a_set_wins : assert property (p_set_wins)
      else $error("Event lost on status read");

   property p_irq_out;
      @(posedge aclk) disable iff (!aresetn)
      (|(st_r.status & st_r.mask)) |-> irq;
   endproperty
   a_irq_out : assert property (p_irq_out)
      else $error("Interrupt low with unmasked status");

   property p_bresp;
      @(posedge aclk) disable iff (!aresetn)
      do_wr |=> (bvalid && !awready && !wready);
   endproperty
   a_bresp : assert property (p_bresp)
      else $error("Write response missing");

endmodule

// ### eipf_src_model.sv
`timescale 1ns/1ps
module eipf_src_model (
   input  wire logic        aclk,
   input  wire logic        cmd_valid,
   input  wire logic [15:0] cmd_level,
   output logic [7:0]       p0_pins,
   output logic [7:0]       p1_pins
);
   // ==========================================================
   // Pin levels of the external source
   initial begin
      p0_pins = 8'h00;
      p1_pins = 8'h00;
   end

   // Each level is held until the next command
   always @(posedge aclk) begin
      if (cmd_valid) begin
         {p1_pins, p0_pins} <= cmd_level;
      end
   end
endmodule

// ### external_interrupt_pin_frontend_tb.sv
`timescale 1ns/1ps
module external_interrupt_pin_frontend_tb;
   import eipf_pkg::*;
   logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic              awready, wready, bvalid, arready, rvalid, irq;
   logic [AXI_AW-1:0] awaddr, araddr;
   logic [31:0]       wdata, rdata, d;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp, rs;
   logic [7:0]        p0_pins, p1_pins, xbar_skip_p0, xbar_skip_p1;
   logic              vec_ack_a, vec_ack_b, irq_a_pending, irq_b_pending;
   logic              cmd_valid, p;
   logic [15:0]       cmd_level, seed, pv;
   logic [2:0]        codes [7];
   logic [7:0]        ra [4];
   logic [31:0]       rv [4];
   int                err_total, check_count;

   eipf_top dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .p0_pins(p0_pins), .p1_pins(p1_pins),
      .vec_ack_a(vec_ack_a), .vec_ack_b(vec_ack_b), .irq_a_pending(irq_a_pending),
      .irq_b_pending(irq_b_pending), .xbar_skip_p0(xbar_skip_p0),
      .xbar_skip_p1(xbar_skip_p1), .irq(irq));

   eipf_src_model src (.aclk(aclk), .cmd_valid(cmd_valid), .cmd_level(cmd_level),
      .p0_pins(p0_pins), .p1_pins(p1_pins));

   // ==========================================================
   // Helpers
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic int pidx(input logic [2:0] c);
      return (c == 3'h5) ? 14 : (c == 3'h7) ? 15 : int'(c);
   endfunction

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tmo(input int n);
      if (n >= 50) begin
         err_total++;
         $display("[ERR] %0t bus wait ran out", $time);
         print_verdict();
      end
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
      int n;
      n = 0;
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid && n < 50);
      tmo(n);
      r = bresp;
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
      int n;
      n = 0;
      araddr  <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid && n < 50);
      tmo(n);
      v = rdata;
      r = rresp;
   endtask

   task automatic setp(input logic [15:0] v);
      cmd_level <= v;
      cmd_valid <= 1'b1;
      @(posedge aclk);
      cmd_valid <= 1'b0;
      repeat (10) @(posedge aclk);
   endtask

   task automatic ack(input logic b);
      if (b) vec_ack_b <= 1'b1;
      else vec_ack_a <= 1'b1;
      @(posedge aclk);
      vec_ack_a <= 1'b0;
      vec_ack_b <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      {aresetn, awvalid, wvalid, arvalid, vec_ack_a, vec_ack_b, cmd_valid} = '0;
      {bready, rready} = 2'b11;
      {awaddr, araddr, wdata, cmd_level} = '0;
      wstrb = 4'hf;
      err_total = 0;
      check_count = 0;
      seed = 16'h865d;
      codes = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
      ra = '{ADDR_CFG, ADDR_TIMER_CONTROL_REG, ADDR_SKIP, ADDR_MASK};
      // Pins low with active-low reset polarity: both level flags pending
      rv = '{32'(CFG_RST), 32'((1 << TC_A_PEND) | (1 << TC_B_PEND)), 32'h0, 32'h0};
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values
      foreach (ra[i]) begin
         axr(ra[i], d, rs);
         chk(d, rv[i]);
         chk(rs, RESP_OKAY);
      end
      $display("test reset done");
      // Level mode over every pin code, opposite polarity per input
      foreach (codes[i]) begin
         seed = nxt(seed);
         p = seed[0];
         axw(ADDR_CFG, {24'h0, ~p, codes[i], p, codes[i]}, rs);
         for (int k = 0; k < 2; k++) begin
            seed = nxt(seed);
            pv = seed;
            pv[pidx(codes[i])] = p ^ k[0];
            setp(pv);
            chk(irq_a_pending, k == 0);
            chk(irq_b_pending, k == 1);
            axr(ADDR_TIMER_CONTROL_REG, d, rs);
            chk(d, {28'h0, k[0], 1'b0, ~k[0], 1'b0});
         end
      end
      $display("test level done");
      // Edge mode with interrupt status and mask
      axw(ADDR_TIMER_CONTROL_REG, 32'h5, rs);
      axw(ADDR_CFG, 32'h18, rs);
      setp(16'h0002);
      axw(ADDR_TIMER_CONTROL_REG, 32'h5, rs);
      axr(ADDR_STAT, d, rs);
      axw(ADDR_MASK, 32'h3, rs);
      setp(16'h0003);
      chk({irq_b_pending, irq_a_pending, irq}, 3'b011);
      setp(16'h0002);
      chk(irq_a_pending, 1'b1);
      axr(ADDR_TIMER_CONTROL_REG, d, rs);
      chk(d, 32'h7);
      axr(ADDR_STAT, d, rs);
      chk(d, 32'h1);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0);
      ack(1'b0);
      chk(irq_a_pending, 1'b0);
      setp(16'h0000);
      chk({irq_b_pending, irq_a_pending, irq}, 3'b101);
      axw(ADDR_MASK, 32'h0, rs);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0);
      ack(1'b1);
      chk(irq_b_pending, 1'b0);
      // Event in the same cycle as the clearing status read
      cmd_level <= 16'h0001;
      cmd_valid <= 1'b1;
      @(posedge aclk);
      cmd_valid <= 1'b0;
      repeat (5) @(posedge aclk);
      axr(ADDR_STAT, d, rs);
      chk(d, 32'h2);
      axr(ADDR_STAT, d, rs);
      chk(d, 32'h1);
      $display("test edge done");
      // Crossbar skip mask and unmapped address
      seed = nxt(seed);
      axw(ADDR_SKIP, {16'h0, seed}, rs);
      chk({xbar_skip_p1, xbar_skip_p0}, seed);
      axr(ADDR_SKIP, d, rs);
      chk(d, {16'h0, seed});
      axw(8'h10, 32'hff, rs);
      chk(rs, RESP_SLVERR);
      axr(8'h10, d, rs);
      chk(d, 32'h0);
      chk(rs, RESP_SLVERR);
      $display("test skip done");
      print_verdict();
   end
endmodule
